// File: splm_gear_scale.sv
`timescale 1ns/10ps
module splm_gear_scale
    import splm_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset,
    // Request
    input  wire logic              start,
    input  wire logic              neg,
    input  wire logic [POS_W-1:0]  mag,
    input  wire logic [POS_W-1:0]  num,
    input  wire logic [POS_W-1:0]  den,
    // Answer
    output logic                   busy,
    output logic                   done,
    output logic signed [DEV_W-1:0] result
);
    splm_div_state_e   state;
    logic [5:0]        cnt;
    logic [PROD_W-1:0] dvd;
    logic [POS_W-1:0]  rem;
    logic              sign;

    wire [PROD_W-1:0] product = PROD_W'(mag) * PROD_W'(num);
    wire [POS_W:0]    trial   = {rem, dvd[PROD_W-1]};
    wire              fits    = trial >= {1'b0, den};
    wire [POS_W:0]    next_rem_w = fits ? trial - {1'b0, den} : trial;
    wire              ovf     = |dvd[PROD_W-1:POS_W];
    wire [POS_W-1:0]  qmag    = ovf ? {POS_W{1'b1}} : dvd[POS_W-1:0];
    wire signed [DEV_W-1:0] signed_q = sign ? -$signed({1'b0, qmag}) : $signed({1'b0, qmag});

    assign busy = (state == DIV_RUN);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state  <= DIV_IDLE;
            cnt    <= 6'h00;
            dvd    <= '0;
            rem    <= '0;
            sign   <= 1'b0;
            done   <= 1'b0;
            result <= '0;
        end else begin
            done <= 1'b0;
            case (state)
                DIV_IDLE: begin
                    if (start) begin
                        dvd   <= product;
                        rem   <= '0;
                        sign  <= neg;
                        cnt   <= 6'h00;
                        state <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    if (cnt == 6'(PROD_W)) begin
                        result <= signed_q;
                        done   <= 1'b1;
                        state  <= DIV_IDLE;
                    end else begin
                        rem <= next_rem_w[POS_W-1:0];
                        dvd <= {dvd[PROD_W-2:0], fits};
                        cnt <= cnt + 6'h01;
                    end
                end
                default: state <= DIV_IDLE;
            endcase
        end
    end
endmodule

// File: splm_host_model.sv
`timescale 1ns/10ps
module splm_host_model
    import splm_pkg::*;
(
    // Clock
    input  wire logic                    core_clk,
    // Answer from the amplifier
    input  wire logic                    cmd_ready,
    input  wire logic                    scaled_valid,
    input  wire logic signed [DEV_W-1:0] scaled_cmd,
    // Network command
    output logic                         cmd_valid,
    output logic signed [DEV_W-1:0]      cmd_delta,
    output logic                         net_torque_limit_en,
    output logic [15:0]                  net_torque_limit_field
);
    initial begin
        cmd_valid = 1'b0;
        cmd_delta = '0;
        net_torque_limit_en = 1'b0;
        net_torque_limit_field = '0;
    end

    // Torque limit field, garbage while disabled
    task automatic set_limit(input logic en, input logic [15:0] pct);
        net_torque_limit_en = en;
        net_torque_limit_field = en ? pct : ~pct;
    endtask

    // Command held until taken, then answer collected
    task automatic send(input int gap, input logic signed [DEV_W-1:0] delta,
                        output logic signed [DEV_W-1:0] res, output logic ok);
        ok = 1'b0;
        res = '0;
        if (gap > 0) begin
            repeat (gap) @(posedge core_clk);
            #1;
        end
        cmd_valid = 1'b1;
        cmd_delta = delta;
        for (int n = 0; n < 200; n++) begin
            @(posedge core_clk);
            if (cmd_ready === 1'b1) break;
        end
        #1;
        cmd_valid = 1'b0;
        cmd_delta = ~delta;
        for (int n = 0; n < 200 && !ok; n++) begin
            @(posedge core_clk);
            if (scaled_valid === 1'b1) begin
                res = scaled_cmd;
                ok = 1'b1;
            end
        end
        #1;
    endtask
endmodule

// File: splm_monitor.sv
`timescale 1ns/10ps
module splm_monitor
    import splm_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // Power-up settings
    input  wire logic [POS_W-1:0]        gear_num,
    input  wire logic [POS_W-1:0]        gear_den,
    input  wire logic                    window_unit,
    input  wire logic [1:0]              in_position_timing,
    input  wire logic [PCT_W-1:0]        overload_base_current,
    input  wire logic                    ovl_retain_in,
    // Live settings
    input  wire logic [POS_W-1:0]        in_position_window,
    input  wire logic [POS_W-1:0]        approach_window,
    input  wire logic [TRQ_W-1:0]        fwd_torque_limit_a,
    input  wire logic [TRQ_W-1:0]        rev_torque_limit_a,
    input  wire logic [TRQ_W-1:0]        fwd_torque_limit_b,
    input  wire logic [TRQ_W-1:0]        rev_torque_limit_b,
    input  wire logic [PCT_W-1:0]        overload_warning_level,
    // Limit select pins
    input  wire logic                    fwd_limit_sel_pin,
    input  wire logic                    rev_limit_sel_pin,
    // Network command
    input  wire logic                    cmd_valid,
    input  wire logic signed [DEV_W-1:0] cmd_delta,
    input  wire logic                    net_torque_limit_en,
    input  wire logic [15:0]             net_torque_limit_field,
    // Position loop
    input  wire logic signed [DEV_W-1:0] dev_command_pulse_unit,
    input  wire logic signed [DEV_W-1:0] dev_feedback_pulse_unit,
    input  wire logic                    filt_cmd_zero,
    input  wire logic                    raw_cmd_zero,
    input  wire logic [TRQ_W-1:0]        motor_current_pct,
    input  wire logic                    alarm_clear,
    // Scaled command
    output logic                         cmd_ready,
    output logic                         scaled_valid,
    output logic signed [DEV_W-1:0]      scaled_cmd,
    // Status
    output logic                         in_position_flag,
    output logic                         approach_flag,
    output logic [TRQ_W-1:0]             fwd_torque_limit_eff,
    output logic [TRQ_W-1:0]             rev_torque_limit_eff,
    output logic                         param_alarm,
    output logic                         alarm_peak,
    output logic                         alarm_cont,
    output logic                         overload_warning,
    output logic                         motor_stop,
    output logic                         ovl_retain_out,
    output logic [9:0]                   alarm_code
);
    // Power-up captured settings
    logic             settled;
    logic [POS_W-1:0] cap_num;
    logic [POS_W-1:0] cap_den;
    logic             cap_unit;
    logic [1:0]       cap_mode;
    logic [PCT_W-1:0] cap_base;
    logic             warn_retain;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            settled  <= 1'b0;
            cap_num  <= GEAR_NUM_RST;
            cap_den  <= GEAR_DEN_RST;
            cap_unit <= 1'b0;
            cap_mode <= MODE_WINDOW;
            cap_base <= BASE_CUR_RST;
        end else if (!settled) begin
            settled  <= 1'b1;
            cap_num  <= gear_num;
            cap_den  <= gear_den;
            cap_unit <= window_unit;
            cap_mode <= in_position_timing;
            cap_base <= overload_base_current;
        end
    end

    // Gear scaling
    logic div_busy;
    wire  start   = cmd_valid && cmd_ready;
    wire  cmd_neg = cmd_delta[DEV_W-1];
    wire [DEV_W-1:0] cmd_abs = cmd_neg ? DEV_W'(-cmd_delta) : DEV_W'(cmd_delta);

    splm_gear_scale u_scale (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (start),
        .neg      (cmd_neg),
        .mag      (cmd_abs[POS_W-1:0]),
        .num      (cap_num),
        .den      (cap_den),
        .busy     (div_busy),
        .done     (scaled_valid),
        .result   (scaled_cmd)
    );

    always_ff @(posedge core_clk) begin
        if (reset)
            cmd_ready <= 1'b0;
        else
            cmd_ready <= settled && !div_busy && !start && !scaled_valid;
    end

    // Gear ratio range check
    wire [41:0] num_k   = 42'(cap_num) * 42'(RATIO_MIN_DIV);
    wire [47:0] den_max = 48'(cap_den) * 48'(RATIO_MAX);
    wire        ratio_bad = (num_k < 42'(cap_den)) || (48'(cap_num) > den_max);

    // Deviation windows
    wire signed [DEV_W-1:0] dev_sel = cap_unit ? dev_feedback_pulse_unit : dev_command_pulse_unit;
    wire [DEV_W-1:0] abs_dev = dev_sel[DEV_W-1] ? DEV_W'(-dev_sel) : DEV_W'(dev_sel);
    wire in_win       = abs_dev <= DEV_W'(in_position_window);
    wire approach_win = abs_dev < DEV_W'(approach_window);
    wire mode_ok  = (cap_mode == MODE_FILT_ZERO) ? filt_cmd_zero :
                    (cap_mode == MODE_RAW_ZERO) ? raw_cmd_zero : 1'b1;

    // Torque limits
    logic fwd_s1, fwd_s2, rev_s1, rev_s2;
    function automatic logic [TRQ_W-1:0] tmin(input logic [TRQ_W-1:0] a, input logic [TRQ_W-1:0] b);
        tmin = (a < b) ? a : b;
    endfunction
    wire [TRQ_W-1:0] net_lim = (net_torque_limit_field > 16'(TRQ_MAX)) ? TRQ_MAX
                             : net_torque_limit_field[TRQ_W-1:0];
    wire [TRQ_W-1:0] net_eff = net_torque_limit_en ? net_lim : TRQ_MAX;
    wire [TRQ_W-1:0] fwd_b   = fwd_s2 ? fwd_torque_limit_b : TRQ_MAX;
    wire [TRQ_W-1:0] rev_b   = rev_s2 ? rev_torque_limit_b : TRQ_MAX;
    wire [TRQ_W-1:0] next_fwd_lim = tmin(tmin(fwd_torque_limit_a, fwd_b), net_eff);
    wire [TRQ_W-1:0] next_rev_lim = tmin(tmin(rev_torque_limit_a, rev_b), net_eff);

    // Overload timing
    localparam int TICK_W = $clog2(TICK_CYC);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
    logic [TICK_W-1:0]           tick_cnt;
    wire                         tick_wrap = (tick_cnt == TICK_LAST);
    logic                        tick;
    logic [7:0]                  peak_cnt;
    logic [ACC_W-1:0]            load_acc;
    wire  over_peak = motor_current_pct > PEAK_CUR_PCT;
    wire  over_base = motor_current_pct > TRQ_W'(cap_base);
    wire [ACC_W-1:0] excess = ACC_W'(motor_current_pct - TRQ_W'(cap_base));
    wire  peak_hit  = tick && over_peak && (peak_cnt == PEAK_HOLD_TICKS - 8'h01);
    wire  cont_hit  = load_acc >= CONT_ALARM_LOAD;
    wire [31:0] acc_pct  = 32'(load_acc) * 32'(PCT_FULL);
    wire [31:0] warn_thr = 32'(CONT_ALARM_LOAD) * 32'(overload_warning_level);
    wire  warn_hit  = acc_pct >= warn_thr;
    wire  next_peak = peak_hit || (alarm_peak && !alarm_clear);
    wire  next_cont = cont_hit || (alarm_cont && !alarm_clear);
    wire  next_retain = (!settled && ovl_retain_in) || (warn_retain && !alarm_clear);
    wire [9:0] next_code = param_alarm ? CODE_PARAM : next_peak ? CODE_PEAK : next_cont ? CODE_CONT
                         : next_retain ? CODE_RETAIN : CODE_NONE;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick     <= tick_wrap;
            tick_cnt <= tick_wrap ? '0 : tick_cnt + TICK_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            peak_cnt <= 8'h00;
            load_acc <= '0;
        end else if (tick) begin
            peak_cnt <= over_peak ? ((peak_cnt == PEAK_HOLD_TICKS) ? peak_cnt : peak_cnt + 8'h01) : 8'h00;
            if (over_base)
                load_acc <= cont_hit ? load_acc : load_acc + excess;
            else
                load_acc <= (load_acc > CONT_DECAY) ? load_acc - CONT_DECAY : '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fwd_s1 <= 1'b0;
            fwd_s2 <= 1'b0;
            rev_s1 <= 1'b0;
            rev_s2 <= 1'b0;
            in_position_flag     <= 1'b0;
            approach_flag        <= 1'b0;
            fwd_torque_limit_eff <= TRQ_A_RST;
            rev_torque_limit_eff <= TRQ_A_RST;
            param_alarm      <= 1'b0;
            alarm_peak       <= 1'b0;
            alarm_cont       <= 1'b0;
            warn_retain      <= 1'b0;
            overload_warning <= 1'b0;
            motor_stop       <= 1'b0;
            ovl_retain_out   <= 1'b0;
            alarm_code       <= CODE_NONE;
        end else begin
            fwd_s1 <= fwd_limit_sel_pin;
            fwd_s2 <= fwd_s1;
            rev_s1 <= rev_limit_sel_pin;
            rev_s2 <= rev_s1;
            in_position_flag     <= settled && in_win && mode_ok;
            approach_flag        <= settled && approach_win;
            fwd_torque_limit_eff <= next_fwd_lim;
            rev_torque_limit_eff <= next_rev_lim;
            param_alarm      <= settled && ratio_bad;
            alarm_peak       <= next_peak;
            alarm_cont       <= next_cont;
            warn_retain      <= next_retain;
            overload_warning <= next_retain || (settled && warn_hit);
            motor_stop       <= next_peak || next_cont || param_alarm;
            ovl_retain_out   <= next_peak || next_cont;
            alarm_code       <= next_code;
        end
    end

    // Checks
    gear_range_a: assert property (@(posedge core_clk) disable iff (reset)
        settled && ratio_bad |=> param_alarm)
        else $error("gear ratio out of range without alarm");
    in_window_a: assert property (@(posedge core_clk) disable iff (reset)
        settled && cap_mode == MODE_WINDOW && abs_dev <= DEV_W'(in_position_window) |=> in_position_flag)
        else $error("in-position flag missing inside window");
    raw_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        cap_mode == MODE_RAW_ZERO && !raw_cmd_zero |=> !in_position_flag)
        else $error("in-position flag set while command not zero");
    unit_sel_a: assert property (@(posedge core_clk) disable iff (reset)
        settled && cap_unit && dev_feedback_pulse_unit == 32'sh0 && cap_mode == MODE_WINDOW |=> in_position_flag)
        else $error("feedback unit deviation not used");
    approach_edge_a: assert property (@(posedge core_clk) disable iff (reset)
        abs_dev >= DEV_W'(approach_window) |=> !approach_flag)
        else $error("approach flag set at or above window");
    torque_min_a: assert property (@(posedge core_clk) disable iff (reset)
        1'b1 |=> fwd_torque_limit_eff <= $past(fwd_torque_limit_a) && rev_torque_limit_eff <= $past(rev_torque_limit_a))
        else $error("torque limit above parameter limit");
    net_both_a: assert property (@(posedge core_clk) disable iff (reset)
        net_torque_limit_en && net_torque_limit_field == 16'h0000 |=> fwd_torque_limit_eff == 10'h000
        && rev_torque_limit_eff == 10'h000)
        else $error("network torque limit not applied to both directions");
    stop_alarm_a: assert property (@(posedge core_clk) disable iff (reset)
        alarm_peak || alarm_cont |-> motor_stop && ovl_retain_out)
        else $error("overload alarm without stop");
    warn_level_a: assert property (@(posedge core_clk) disable iff (reset)
        settled && warn_hit |=> overload_warning)
        else $error("overload warning missing");
    hold_cfg_a: assert property (@(posedge core_clk) disable iff (reset)
        settled |=> $stable(cap_num) && $stable(cap_den) && $stable(cap_unit) && $stable(cap_mode)
        && $stable(cap_base))
        else $error("power-up settings changed");
    scale_done_a: assert property (@(posedge core_clk) disable iff (reset)
        start |-> ##[64:66] scaled_valid)
        else $error("scaled command late");
endmodule

// File: splm_monitor_test.sv
`timescale 1ns/10ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR t=%0t got %0h expected %0h", $time, (got), (exp)); end end
module splm_monitor_test
    import splm_pkg::*;
;
    // Design inputs
    logic                    core_clk = 1'b0;
    logic                    reset = 1'b1;
    logic [POS_W-1:0]        gear_num, gear_den, in_position_window, approach_window;
    logic                    window_unit, ovl_retain_in, fwd_limit_sel_pin, rev_limit_sel_pin;
    logic                    filt_cmd_zero, raw_cmd_zero, alarm_clear;
    logic [1:0]              in_position_timing;
    logic [PCT_W-1:0]        overload_base_current, overload_warning_level;
    logic [TRQ_W-1:0]        fwd_torque_limit_a, rev_torque_limit_a, fwd_torque_limit_b, rev_torque_limit_b;
    logic [TRQ_W-1:0]        motor_current_pct, fwd_torque_limit_eff, rev_torque_limit_eff;
    logic signed [DEV_W-1:0] dev_command_pulse_unit, dev_feedback_pulse_unit, cmd_delta, scaled_cmd, res;
    // Host side and outputs
    logic                    cmd_valid, net_torque_limit_en, cmd_ready, scaled_valid, ok;
    logic [15:0]             net_torque_limit_field;
    logic                    in_position_flag, approach_flag, param_alarm, alarm_peak, alarm_cont;
    logic                    overload_warning, motor_stop, ovl_retain_out;
    logic [9:0]              alarm_code;
    int                      failures = 0;
    int                      cmp_count = 0;
    int                      n;
    logic [POS_W-1:0]        r_num [4] = '{31'h1, 31'h1, 31'hfa00, 31'hfa01};
    logic [POS_W-1:0]        r_den [4] = '{31'h3e8, 31'h3e9, 31'h1, 31'h1};
    logic                    r_bad [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    always #20 core_clk = ~core_clk;

    splm_monitor #(.TICK_CYC(4)) i_dut (
        .core_clk(core_clk), .reset(reset), .gear_num(gear_num), .gear_den(gear_den),
        .window_unit(window_unit), .in_position_timing(in_position_timing), .ovl_retain_in(ovl_retain_in),
        .overload_base_current(overload_base_current), .in_position_window(in_position_window),
        .approach_window(approach_window), .fwd_torque_limit_a(fwd_torque_limit_a),
        .rev_torque_limit_a(rev_torque_limit_a), .fwd_torque_limit_b(fwd_torque_limit_b),
        .rev_torque_limit_b(rev_torque_limit_b), .overload_warning_level(overload_warning_level),
        .fwd_limit_sel_pin(fwd_limit_sel_pin), .rev_limit_sel_pin(rev_limit_sel_pin),
        .cmd_valid(cmd_valid), .cmd_delta(cmd_delta), .net_torque_limit_en(net_torque_limit_en),
        .net_torque_limit_field(net_torque_limit_field), .dev_command_pulse_unit(dev_command_pulse_unit),
        .dev_feedback_pulse_unit(dev_feedback_pulse_unit), .filt_cmd_zero(filt_cmd_zero),
        .raw_cmd_zero(raw_cmd_zero), .motor_current_pct(motor_current_pct), .alarm_clear(alarm_clear),
        .cmd_ready(cmd_ready), .scaled_valid(scaled_valid), .scaled_cmd(scaled_cmd),
        .in_position_flag(in_position_flag), .approach_flag(approach_flag),
        .fwd_torque_limit_eff(fwd_torque_limit_eff), .rev_torque_limit_eff(rev_torque_limit_eff),
        .param_alarm(param_alarm), .alarm_peak(alarm_peak), .alarm_cont(alarm_cont),
        .overload_warning(overload_warning), .motor_stop(motor_stop), .ovl_retain_out(ovl_retain_out),
        .alarm_code(alarm_code)
    );

    splm_host_model i_host (
        .core_clk(core_clk), .cmd_ready(cmd_ready), .scaled_valid(scaled_valid), .scaled_cmd(scaled_cmd),
        .cmd_valid(cmd_valid), .cmd_delta(cmd_delta), .net_torque_limit_en(net_torque_limit_en),
        .net_torque_limit_field(net_torque_limit_field)
    );

    task automatic step(input int cycles);
        repeat (cycles) @(posedge core_clk);
        #1;
    endtask

    task automatic power_up();
        reset = 1'b1;
        step(6);
        reset = 1'b0;
        step(3);
    endtask

    task automatic scale(input int gap, input logic signed [DEV_W-1:0] d, input logic signed [DEV_W-1:0] exp);
        i_host.send(gap, d, res, ok);
        `CHECK(ok, 1'b1)
        `CHECK(res, exp)
    endtask

    // Deviation on the selected unit, the other unit far outside
    task automatic pos(input logic signed [DEV_W-1:0] d, input logic ip, input logic ap);
        dev_command_pulse_unit = window_unit ? 32'sh1388 : d;
        dev_feedback_pulse_unit = window_unit ? d : 32'sh1388;
        step(2);
        `CHECK(in_position_flag, ip)
        `CHECK(approach_flag, ap)
    endtask

    task automatic pulse_clear();
        alarm_clear = 1'b1;
        step(1);
        alarm_clear = 1'b0;
        step(2);
    endtask

    task automatic end_test(input string name);
        $display("test %s done, %0d mismatches so far", name, failures);
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        failures++;
        $display("ERROR t=%0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        {window_unit, ovl_retain_in, fwd_limit_sel_pin, rev_limit_sel_pin} = 4'h0;
        {filt_cmd_zero, raw_cmd_zero, alarm_clear, in_position_timing} = 5'h00;
        {gear_num, gear_den} = {GEAR_NUM_RST, GEAR_DEN_RST};
        {in_position_window, approach_window} = {WINDOW_RST, WINDOW_RST};
        {overload_base_current, overload_warning_level} = {BASE_CUR_RST, WARN_LVL_RST};
        {fwd_torque_limit_a, rev_torque_limit_a} = {TRQ_A_RST, TRQ_A_RST};
        {fwd_torque_limit_b, rev_torque_limit_b} = {TRQ_B_RST, TRQ_B_RST};
        {dev_command_pulse_unit, dev_feedback_pulse_unit} = {32'sh1388, 32'sh1388};
        motor_current_pct = '0;
        power_up();
        `CHECK(fwd_torque_limit_eff, TRQ_A_RST)
        `CHECK(rev_torque_limit_eff, TRQ_A_RST)
        scale(0, 32'sh0a, 32'sh28);
        scale(0, -32'sh7, -32'sh1c);
        gear_num = 31'h3;
        gear_den = 31'h2;
        scale(3, 32'sh5, 32'sh14);
        power_up();
        scale(0, 32'sh5, 32'sh7);
        scale(2, -32'sh5, -32'sh7);
        end_test("gear scaling");
        for (int i = 0; i < 4; i++) begin
            gear_num = r_num[i];
            gear_den = r_den[i];
            power_up();
            `CHECK(param_alarm, r_bad[i])
            `CHECK(alarm_code, r_bad[i] ? CODE_PARAM : CODE_NONE)
        end
        end_test("gear ratio range");
        {gear_num, gear_den} = {GEAR_NUM_RST, GEAR_DEN_RST};
        power_up();
        pos(32'sh19, 1'b1, 1'b0);
        pos(-32'sh18, 1'b1, 1'b1);
        pos(32'sh1a, 1'b0, 1'b0);
        in_position_window = '0;
        approach_window = 31'h1;
        pos(32'sh0, 1'b1, 1'b1);
        pos(-32'sh1, 1'b0, 1'b0);
        {in_position_window, approach_window} = {WINDOW_RST, WINDOW_RST};
        for (int m = 0; m < 3; m++) begin
            in_position_timing = m[1:0];
            window_unit = (m != 1);
            {filt_cmd_zero, raw_cmd_zero} = 2'h0;
            power_up();
            pos(32'sh3, m == 0, 1'b1);
            filt_cmd_zero = 1'b1;
            pos(-32'sh3, m != 2, 1'b1);
            raw_cmd_zero = 1'b1;
            pos(32'sh0, 1'b1, 1'b1);
        end
        end_test("position flags");
        {fwd_torque_limit_a, rev_torque_limit_a} = {10'h1f4, 10'h258};
        {fwd_torque_limit_b, rev_torque_limit_b} = {10'h0c8, 10'h2bc};
        step(2);
        `CHECK(fwd_torque_limit_eff, 10'h1f4)
        {fwd_limit_sel_pin, rev_limit_sel_pin} = 2'h3;
        step(4);
        `CHECK(fwd_torque_limit_eff, 10'h0c8)
        `CHECK(rev_torque_limit_eff, 10'h258)
        i_host.set_limit(1'b1, 16'h012c);
        step(2);
        `CHECK(fwd_torque_limit_eff, 10'h0c8)
        `CHECK(rev_torque_limit_eff, 10'h12c)
        i_host.set_limit(1'b1, 16'h03e8);
        step(2);
        `CHECK(rev_torque_limit_eff, 10'h258)
        i_host.set_limit(1'b1, 16'h0000);
        step(2);
        `CHECK(fwd_torque_limit_eff, 10'h000)
        `CHECK(rev_torque_limit_eff, 10'h000)
        i_host.set_limit(1'b0, 16'h0000);
        end_test("torque limits");
        motor_current_pct = 10'h12d;
        for (n = 0; n < 200 && alarm_peak !== 1'b1; n++) step(1);
        `CHECK(n > 30, 1'b1)
        `CHECK(motor_stop, 1'b1)
        `CHECK(alarm_code, CODE_PEAK)
        `CHECK(ovl_retain_out, 1'b1)
        motor_current_pct = '0;
        pulse_clear();
        `CHECK(alarm_peak, 1'b0)
        overload_base_current = 7'h32;
        power_up();
        motor_current_pct = 10'h064;
        for (n = 0; n < 600 && overload_warning !== 1'b1; n++) step(1);
        `CHECK(n > 280, 1'b1)
        `CHECK(alarm_cont, 1'b0)
        overload_warning_level = 7'h64;
        step(2);
        `CHECK(overload_warning, 1'b0)
        for (n = 0; n < 2000 && alarm_cont !== 1'b1; n++) step(1);
        `CHECK(n > 1000, 1'b1)
        `CHECK(alarm_code, CODE_CONT)
        `CHECK(motor_stop, 1'b1)
        motor_current_pct = '0;
        ovl_retain_in = 1'b1;
        power_up();
        `CHECK(overload_warning, 1'b1)
        `CHECK(alarm_code, CODE_RETAIN)
        ovl_retain_in = 1'b0;
        pulse_clear();
        `CHECK(overload_warning, 1'b0)
        end_test("overload");
        stop_test();
    end
endmodule

// File: splm_pkg.sv
// How it works
// - The in-position flag is raised while the absolute deviation lies within the in-position window (0 to 2^30, default 25).
// - The window unit setting picks command-pulse deviation (0, default) or feedback-pulse deviation (1) for both windows.
// - Timing mode 0 needs only the window, mode 1 also needs the filtered command at zero, mode 2 the raw command at zero.
// - The approach flag is raised while the absolute deviation is strictly below the approach window (default 25).
// - Each position command is multiplied by the gear numerator and divided by the gear denominator (defaults 4 and 1).
// - A gear ratio below 0.001 or above 64000 raises parameter alarm 040.
// - Two forward and two reverse torque limits of 0 to 800 percent apply at once when changed (defaults 800 and 100).
// - The torque limit field of the network command is applied as a torque limit.
// - Load above rating raises peak overload alarm 710 or continuous overload alarm 720 and stops the motor.
// - The continuous overload current threshold follows the base current setting, 10 to 100 percent, default 100.
// - An overload alarm active at power loss gives overload warning 910 at the next power-up.
// - The overload warning level, 1 to 100 percent of the alarm load, default 20, applies at once.
// - With several torque limits active the smallest one is applied.
// - The network torque limit is applied as one magnitude to both directions.
package splm_pkg;
    localparam int CLK_MHZ = 25;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;

    localparam int POS_W = 31;
    localparam int DEV_W = 32;
    localparam int TRQ_W = 10;
    localparam int PCT_W = 7;
    localparam int PROD_W = 62;
    localparam int ACC_W = 24;

    localparam logic [POS_W-1:0] GEAR_NUM_RST = 31'h0000_0004;
    localparam logic [POS_W-1:0] GEAR_DEN_RST = 31'h0000_0001;
    localparam logic [POS_W-1:0] WINDOW_RST = 31'h0000_0019;
    localparam logic [TRQ_W-1:0] TRQ_A_RST = 10'h320;
    localparam logic [TRQ_W-1:0] TRQ_B_RST = 10'h064;
    localparam logic [TRQ_W-1:0] TRQ_MAX = 10'h320;
    localparam logic [PCT_W-1:0] BASE_CUR_RST = 7'h64;
    localparam logic [PCT_W-1:0] WARN_LVL_RST = 7'h14;

    localparam logic [10:0] RATIO_MIN_DIV = 11'h3e8;
    localparam logic [15:0] RATIO_MAX = 16'hfa00;
    localparam logic [6:0] PCT_FULL = 7'h64;

    localparam logic [1:0] MODE_WINDOW = 2'h0;
    localparam logic [1:0] MODE_FILT_ZERO = 2'h1;
    localparam logic [1:0] MODE_RAW_ZERO = 2'h2;

    localparam logic [TRQ_W-1:0] PEAK_CUR_PCT = 10'h12c;
    localparam logic [7:0] PEAK_HOLD_TICKS = 8'h0a;
    localparam logic [ACC_W-1:0] CONT_ALARM_LOAD = 24'h00_4e20;
    localparam logic [ACC_W-1:0] CONT_DECAY = 24'h00_0005;

    localparam logic [9:0] CODE_NONE = 10'h000;
    localparam logic [9:0] CODE_PARAM = 10'h028;
    localparam logic [9:0] CODE_PEAK = 10'h2c6;
    localparam logic [9:0] CODE_CONT = 10'h2d0;
    localparam logic [9:0] CODE_RETAIN = 10'h38e;

    typedef enum logic {DIV_IDLE, DIV_RUN} splm_div_state_e;
endpackage
